// ---- verilog/gpio_port_regs.vh ----
// Constants for the port input-mode and pin interrupt flag block.
// Assumes a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// Register indices; byte address is four times the index
`define IDX_P0_FLAGS      8'h89
`define IDX_P1_FLAGS      8'h8a
`define IDX_P2_FLAGS      8'h8b
`define IDX_PORT_IRQ_CTL  8'h8c
`define IDX_P1_IRQ_EN     8'h8d
`define IDX_P0_INMODE     8'h8f
`define IDX_P1_INMODE     8'hf6
`define IDX_P2_INMODE     8'hf7
`define IDX_IRQ_STATUS    8'he0
`define IDX_IRQ_MASK      8'he1

// Reset values
`define RST_BYTE          8'h00
`define RST_EVT           3'h0
`define RST_P2_FLAGS      5'h00
`define P0_PULL_RST       8'hff
`define P2_PULL_RST       5'h1f

// Field positions in the port 2 input-mode register
`define P2_PULL_DIR_BIT   7
`define P1_PULL_DIR_BIT   6
`define P0_PULL_DIR_BIT   5
`define P2_MODE_MSB       4

// Field positions in the port interrupt control register
`define CTL_P2_IRQ_EN     5
`define CTL_P0_UPPER_EN   4
`define CTL_P0_LOWER_EN   3
`define CTL_P2_EDGE       2
`define CTL_P1_EDGE       1
`define CTL_P0_EDGE       0
`define CTL_RW_MASK       8'h7f

// Writable masks
`define P1_MODE_MASK      8'hfc
`define P2_FLAG_MASK      8'h1f

// Bus answers
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// ---- verilog/pin_edge_detect.v ----
// Pin synchroniser with selectable rising or falling edge detection.
// Assumes asynchronous pin inputs and a single system clock.
`timescale 1ns/1ns

module pin_edge_detect #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             srst,
    // Pins and control
    input  wire [WIDTH-1:0] pin_in,
    input  wire             fall_sel,
    // Edge pulses
    output reg  [WIDTH-1:0] edge_ff
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    reg [WIDTH-1:0] last_ff;
    reg             fill1_ff;
    reg             fill2_ff;
    reg             armed_ff;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (srst) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
            last_ff <= {WIDTH{1'b0}};
            edge_ff <= {WIDTH{1'b0}};
            fill1_ff <= 1'b0;
            fill2_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
            // Pulled pins idle high; no edge until last stage holds a real sample
            fill1_ff <= 1'b1;
            fill2_ff <= fill1_ff;
            armed_ff <= fill2_ff;
            if (fall_sel) begin
                edge_ff <= last_ff & ~sync_ff & {WIDTH{armed_ff}};
            end else begin
                edge_ff <= sync_ff & ~last_ff & {WIDTH{armed_ff}};
            end
        end
    end

endmodule

// ---- verilog/gpio_port_irq.v ----
// Input-mode control and per-pin interrupt flags for three I/O ports.
// Assumes an AXI4-Lite master on clk; pins are asynchronous to clk.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "gpio_port_regs.vh"

// Behaviour
// - Port 0 eight mode bits, 1 tristate
// - Port 1 mode bits 7:2 only
// - Port 2 mode bits 4:0
// - One pull direction bit per port
// - Pin request sets same-index flag
// - Ports 0,1 flags cleared by writing zero
// - Port 2 flags 4:0, upper read zero
// - Edge select: rising 0, falling 1
// - Port 0 split enables, port 2 shared
// - Port 1 per-pin enable bits
module gpio_port_irq #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input  wire              clk,
    input  wire              srst,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Pin inputs
    input  wire [7:0]        port0_pin,
    input  wire [7:0]        port1_pin,
    input  wire [4:0]        port2_pin,
    // Pad pull controls
    output reg  [7:0]        port0_pull_en,
    output reg  [7:0]        port1_pull_en,
    output reg  [4:0]        port2_pull_en,
    output reg               port0_pull_direction,
    output reg               port1_pull_direction,
    output reg               port2_pull_direction,
    // Processor interrupt requests
    output reg               port0_cpu_irq,
    output reg               port1_cpu_irq,
    output reg               port2_cpu_irq,
    output reg               irq
);

    // Registers
    reg [7:0]        port0_input_mode_ff;
    reg [7:0]        port1_input_mode_ff;
    reg [7:0]        port2_input_mode_and_pull_select_ff;
    reg [7:0]        port0_irq_flag_bits_ff;
    reg [7:0]        port1_irq_flag_bits_ff;
    reg [4:0]        port2_irq_flag_bits_ff;
    reg [7:0]        port_irq_ctl_ff;
    reg [7:0]        port1_pin_irq_enable_ff;
    reg [2:0]        irq_status_ff;
    reg [2:0]        irq_mask_ff;

    // Bus state
    reg              aw_got_ff;
    reg              w_got_ff;
    reg [ADDR_W-1:0] awaddr_ff;
    reg [31:0]       wdata_ff;
    reg              wstrb0_ff;

    reg              nxt_aw_got;
    reg              nxt_w_got;
    reg              nxt_bvalid;
    reg              nxt_rvalid;
    reg              do_write;
    reg              ar_take;

    // Decoded accesses
    wire [7:0]       wr_idx;
    wire [7:0]       rd_idx;
    reg              wr_hit;
    reg [7:0]        rd_val;
    reg              rd_hit;

    // Edge pulses
    wire [7:0]       p0_edge;
    wire [7:0]       p1_edge;
    wire [4:0]       p2_edge;

    // Flag updates
    reg [7:0]        nxt_p0_flags;
    reg [7:0]        nxt_p1_flags;
    reg [4:0]        nxt_p2_flags;
    reg [7:0]        p0_en_vec;
    reg [2:0]        new_evt;
    reg [2:0]        nxt_status;

    assign wr_idx = awaddr_ff[9:2];
    assign rd_idx = s_axi_araddr[9:2];

    pin_edge_detect #(
        .WIDTH (8)
    ) u_p0_edge (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (port0_pin),
        .fall_sel (port_irq_ctl_ff[`CTL_P0_EDGE]),
        .edge_ff  (p0_edge)
    );

    pin_edge_detect #(
        .WIDTH (8)
    ) u_p1_edge (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (port1_pin),
        .fall_sel (port_irq_ctl_ff[`CTL_P1_EDGE]),
        .edge_ff  (p1_edge)
    );

    pin_edge_detect #(
        .WIDTH (5)
    ) u_p2_edge (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (port2_pin),
        .fall_sel (port_irq_ctl_ff[`CTL_P2_EDGE]),
        .edge_ff  (p2_edge)
    );

    // Handshake bookkeeping; one write and one read in flight
    always @* begin
        nxt_aw_got = aw_got_ff | (s_axi_awvalid & s_axi_awready);
        nxt_w_got  = w_got_ff | (s_axi_wvalid & s_axi_wready);
        do_write   = aw_got_ff & w_got_ff;
        nxt_bvalid = s_axi_bvalid & ~s_axi_bready;
        if (do_write) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
        end
        ar_take    = s_axi_arvalid & s_axi_arready;
        nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
    end

    always @* begin
        wr_hit = 1'b1;
        if (wr_idx == `IDX_P0_FLAGS) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P1_FLAGS) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P2_FLAGS) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_PORT_IRQ_CTL) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P1_IRQ_EN) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P0_INMODE) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P1_INMODE) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_P2_INMODE) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_IRQ_STATUS) begin
            wr_hit = 1'b1;
        end else if (wr_idx == `IDX_IRQ_MASK) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Read mux; unused bits read as zero, except control bit 6, which is writable and reads back
    always @* begin
        rd_hit = 1'b1;
        rd_val = `RST_BYTE;
        if (rd_idx == `IDX_P0_FLAGS) begin
            rd_val = port0_irq_flag_bits_ff;
        end else if (rd_idx == `IDX_P1_FLAGS) begin
            rd_val = port1_irq_flag_bits_ff;
        end else if (rd_idx == `IDX_P2_FLAGS) begin
            rd_val = {3'h0, port2_irq_flag_bits_ff};
        end else if (rd_idx == `IDX_PORT_IRQ_CTL) begin
            rd_val = port_irq_ctl_ff;
        end else if (rd_idx == `IDX_P1_IRQ_EN) begin
            rd_val = port1_pin_irq_enable_ff;
        end else if (rd_idx == `IDX_P0_INMODE) begin
            rd_val = port0_input_mode_ff;
        end else if (rd_idx == `IDX_P1_INMODE) begin
            rd_val = port1_input_mode_ff;
        end else if (rd_idx == `IDX_P2_INMODE) begin
            rd_val = port2_input_mode_and_pull_select_ff;
        end else if (rd_idx == `IDX_IRQ_STATUS) begin
            rd_val = {5'h00, irq_status_ff};
        end else if (rd_idx == `IDX_IRQ_MASK) begin
            rd_val = {5'h00, irq_mask_ff};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Flag next state: clear by written zeros, set wins
    always @* begin
        nxt_p0_flags = port0_irq_flag_bits_ff;
        nxt_p1_flags = port1_irq_flag_bits_ff;
        nxt_p2_flags = port2_irq_flag_bits_ff;
        if (do_write && wstrb0_ff) begin
            if (wr_idx == `IDX_P0_FLAGS) begin
                nxt_p0_flags = port0_irq_flag_bits_ff & wdata_ff[7:0];
            end else if (wr_idx == `IDX_P1_FLAGS) begin
                nxt_p1_flags = port1_irq_flag_bits_ff & wdata_ff[7:0];
            end else if (wr_idx == `IDX_P2_FLAGS) begin
                nxt_p2_flags = port2_irq_flag_bits_ff & wdata_ff[4:0];
            end
        end
        nxt_p0_flags = nxt_p0_flags | p0_edge;
        nxt_p1_flags = nxt_p1_flags | p1_edge;
        nxt_p2_flags = nxt_p2_flags | p2_edge;
    end

    // Enabled new requests become sticky events
    always @* begin
        p0_en_vec = {{4{port_irq_ctl_ff[`CTL_P0_UPPER_EN]}},
                     {4{port_irq_ctl_ff[`CTL_P0_LOWER_EN]}}};
        new_evt[0] = |(p0_edge & p0_en_vec);
        new_evt[1] = |(p1_edge & port1_pin_irq_enable_ff);
        new_evt[2] = |p2_edge & port_irq_ctl_ff[`CTL_P2_IRQ_EN];
        nxt_status = irq_status_ff;
        if (ar_take && rd_idx == `IDX_IRQ_STATUS) begin
            nxt_status = `RST_EVT;
        end
        // Event in the clearing cycle is kept
        nxt_status = nxt_status | new_evt;
    end

    // Bus handshake registers
    always @(posedge clk) begin
        if (srst) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= {ADDR_W{1'b0}};
            wdata_ff      <= 32'h0000_0000;
            wstrb0_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            aw_got_ff     <= nxt_aw_got;
            w_got_ff      <= nxt_w_got;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff  <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            // Ready only while nothing is held or owed
            s_axi_awready <= ~nxt_aw_got & ~nxt_bvalid & ~do_write;
            s_axi_wready  <= ~nxt_w_got & ~nxt_bvalid & ~do_write;
            s_axi_bvalid  <= nxt_bvalid;
            if (do_write) begin
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
            end
            s_axi_arready <= ~nxt_rvalid;
            s_axi_rvalid  <= nxt_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h00_0000, rd_val};
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
            end
        end
    end

    // Software registers and flags
    always @(posedge clk) begin
        if (srst) begin
            port0_input_mode_ff                 <= `RST_BYTE;
            port1_input_mode_ff                 <= `RST_BYTE;
            port2_input_mode_and_pull_select_ff <= `RST_BYTE;
            port_irq_ctl_ff                     <= `RST_BYTE;
            port1_pin_irq_enable_ff             <= `RST_BYTE;
            irq_mask_ff                         <= `RST_EVT;
            irq_status_ff                       <= `RST_EVT;
            port0_irq_flag_bits_ff              <= `RST_BYTE;
            port1_irq_flag_bits_ff              <= `RST_BYTE;
            port2_irq_flag_bits_ff              <= `RST_P2_FLAGS;
        end else begin
            port0_irq_flag_bits_ff <= nxt_p0_flags;
            port1_irq_flag_bits_ff <= nxt_p1_flags;
            port2_irq_flag_bits_ff <= nxt_p2_flags;
            irq_status_ff          <= nxt_status;
            if (do_write && wstrb0_ff) begin
                if (wr_idx == `IDX_P0_INMODE) begin
                    port0_input_mode_ff <= wdata_ff[7:0];
                end else if (wr_idx == `IDX_P1_INMODE) begin
                    port1_input_mode_ff <= wdata_ff[7:0] & `P1_MODE_MASK;
                end else if (wr_idx == `IDX_P2_INMODE) begin
                    port2_input_mode_and_pull_select_ff <= wdata_ff[7:0];
                end else if (wr_idx == `IDX_PORT_IRQ_CTL) begin
                    // Top bit reads zero
                    port_irq_ctl_ff <= wdata_ff[7:0] & `CTL_RW_MASK;
                end else if (wr_idx == `IDX_P1_IRQ_EN) begin
                    port1_pin_irq_enable_ff <= wdata_ff[7:0];
                end else if (wr_idx == `IDX_IRQ_MASK) begin
                    irq_mask_ff <= wdata_ff[2:0];
                end
            end
        end
    end

    // Pad controls and interrupt outputs, all registered
    always @(posedge clk) begin
        if (srst) begin
            port0_pull_en        <= `P0_PULL_RST;
            port1_pull_en        <= `P1_MODE_MASK;
            port2_pull_en        <= `P2_PULL_RST;
            port0_pull_direction <= 1'b0;
            port1_pull_direction <= 1'b0;
            port2_pull_direction <= 1'b0;
            port0_cpu_irq        <= 1'b0;
            port1_cpu_irq        <= 1'b0;
            port2_cpu_irq        <= 1'b0;
            irq                  <= 1'b0;
        end else begin
            port0_pull_en <= ~port0_input_mode_ff;
            // Pins 1:0 of port 1 have no pull control
            port1_pull_en <= ~port1_input_mode_ff & `P1_MODE_MASK;
            port2_pull_en <= ~port2_input_mode_and_pull_select_ff[`P2_MODE_MSB:0];
            port0_pull_direction <= port2_input_mode_and_pull_select_ff[`P0_PULL_DIR_BIT];
            port1_pull_direction <= port2_input_mode_and_pull_select_ff[`P1_PULL_DIR_BIT];
            port2_pull_direction <= port2_input_mode_and_pull_select_ff[`P2_PULL_DIR_BIT];
            port0_cpu_irq <= |(port0_irq_flag_bits_ff & p0_en_vec);
            port1_cpu_irq <= |(port1_irq_flag_bits_ff & port1_pin_irq_enable_ff);
            port2_cpu_irq <= |port2_irq_flag_bits_ff & port_irq_ctl_ff[`CTL_P2_IRQ_EN];
            irq           <= |(irq_status_ff & irq_mask_ff);
        end
    end

endmodule

// ---- sim/gpio_port_irq_sva.sv ----
// Concurrent checks on the bus handshake and pad outputs of the port block.
// Bound to gpio_port_irq; one clock, synchronous active-high reset.
`timescale 1ns/1ns
module gpio_port_irq_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins and pads
    input wire logic [7:0]  port1_pin,
    input wire logic [7:0]  port0_pull_en,
    input wire logic [7:0]  port1_pull_en,
    input wire logic [4:0]  port2_pull_en,
    input wire logic        port0_pull_direction,
    input wire logic        port1_pull_direction,
    input wire logic        port2_pull_direction,
    // Interrupts
    input wire logic        port1_cpu_irq,
    input wire logic        irq
);
    logic [7:0] p1_pin_q;
    logic [3:0] p1_quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Cycles since port 1 pins last moved, saturating
    always @(posedge clk) begin
        p1_pin_q <= port1_pin;
        if (srst || p1_pin_q != port1_pin) p1_quiet <= 4'h0;
        else if (p1_quiet != 4'hf) p1_quiet <= p1_quiet + 4'h1;
    end

    a_pull_on_write: assert property (
        $changed({port0_pull_en, port1_pull_en, port2_pull_en})
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("pull change without write");
    a_p1_low_unpulled: assert property (
        port1_pull_en[1:0] == 2'b00) else $error("port 1 low pins pulled");
    a_dir_on_write: assert property (
        $changed({port0_pull_direction, port1_pull_direction, port2_pull_direction})
        |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("direction change without write");
    a_p1_irq_cause: assert property (
        $rose(port1_cpu_irq) |-> p1_quiet <= 4'h7 || $past(s_axi_bvalid))
        else $error("port 1 request without cause");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[2:3] s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
    a_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");

    c_p1_irq: cover property ($rose(port1_cpu_irq));
    c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
    c_irq_clear: cover property ($fell(irq));
endmodule

bind gpio_port_irq gpio_port_irq_sva chk_u (.clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .port1_pin, .port0_pull_en, .port1_pull_en, .port2_pull_en, .port0_pull_direction,
    .port1_pull_direction, .port2_pull_direction, .port1_cpu_irq, .irq);

// ---- sim/pin_source.sv ----
// Model of the external circuit on the 21 port pins.
// Bench sets drive and levels; released pins show the pad pull or float.
`timescale 1ns/1ns
module pin_source (
    // Clock
    input  wire logic        clk,
    // Bench control
    input  wire logic        drive,
    input  wire logic [20:0] level,
    // Pad pull state
    input  wire logic [20:0] pull_en,
    input  wire logic [2:0]  pull_dn,
    // Pins
    output logic      [20:0] pins
);
    initial pins = 21'h00_0000;
    always @(posedge clk) begin
        for (int i = 0; i < 21; i++) begin
            if (drive) pins[i] <= level[i];
            else if (pull_en[i]) pins[i] <= ~pull_dn[int'(i >= 8) + int'(i >= 16)];
            // Floating pin: never trust the last level
            else pins[i] <= ~pins[i];
        end
    end
endmodule

// ---- sim/port_input_mode_and_pin_irq_flags_test.sv ----
// Bench for the port block: bus tasks, reference model, random pin edges.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`include "gpio_port_regs.vh"
module port_input_mode_and_pin_irq_flags_test;
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, drive;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [20:0] lvl, pins;
    wire         awready, wready, bvalid, arready, rvalid, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  pe0, pe1;
    wire  [4:0]  pe2;
    wire  [2:0]  dir, cpu;
    int          m [int];
    int          seed, num_errors, samples_checked;
    int          mapped [10] = '{`IDX_P0_FLAGS, `IDX_P1_FLAGS, `IDX_P2_FLAGS, `IDX_PORT_IRQ_CTL,
        `IDX_P1_IRQ_EN, `IDX_P0_INMODE, `IDX_P1_INMODE, `IDX_P2_INMODE, `IDX_IRQ_STATUS,
        `IDX_IRQ_MASK};

    gpio_port_irq dut_u (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port0_pin(pins[7:0]), .port1_pin(pins[15:8]), .port2_pin(pins[20:16]),
        .port0_pull_en(pe0), .port1_pull_en(pe1), .port2_pull_en(pe2),
        .port0_pull_direction(dir[0]), .port1_pull_direction(dir[1]),
        .port2_pull_direction(dir[2]), .port0_cpu_irq(cpu[0]), .port1_cpu_irq(cpu[1]),
        .port2_cpu_irq(cpu[2]), .irq(irq));
    pin_source pins_u (.clk(clk), .drive(drive), .level(lvl), .pull_en({pe2, pe1, pe0}),
        .pull_dn(dir), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        chk("bvalid", 1, bvalid);
        chk("bresp", m.exists(idx) ? `RESP_OKAY : `RESP_DECERR, bresp);
        bready <= 1'b0;
        if (m.exists(idx)) case (idx)
            `IDX_P0_FLAGS, `IDX_P1_FLAGS, `IDX_P2_FLAGS: m[idx] &= d;
            `IDX_P1_INMODE: m[idx] = d & `P1_MODE_MASK;
            `IDX_PORT_IRQ_CTL: m[idx] = d & `CTL_RW_MASK;
            `IDX_IRQ_MASK: m[idx] = d & 8'h07;
            `IDX_IRQ_STATUS: ;
            default: m[idx] = d;
        endcase
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        repeat (40) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        chk("rvalid", 1, rvalid);
        chk("rresp", m.exists(idx) ? `RESP_OKAY : `RESP_DECERR, rresp);
        chk("rdata", m.exists(idx) ? m[idx] & 32'h0000_00ff : 32'h0000_0000, rdata);
        rready <= 1'b0;
        // Status read clears it
        if (idx == `IDX_IRQ_STATUS) m[idx] = 0;
    endtask

    task automatic pins_to(input logic [20:0] nv);
        logic [20:0] r, e;
        logic [7:0]  c;
        c = 8'(m[`IDX_PORT_IRQ_CTL]);
        r = ~lvl & nv;
        e = lvl & ~nv;
        e = {c[2] ? e[20:16] : r[20:16], c[1] ? e[15:8] : r[15:8], c[0] ? e[7:0] : r[7:0]};
        m[`IDX_P0_FLAGS] |= e[7:0];
        m[`IDX_P1_FLAGS] |= e[15:8];
        m[`IDX_P2_FLAGS] |= e[20:16];
        if ((c[4] && e[7:4] != 0) || (c[3] && e[3:0] != 0)) m[`IDX_IRQ_STATUS] |= 1;
        if ((e[15:8] & m[`IDX_P1_IRQ_EN]) != 0) m[`IDX_IRQ_STATUS] |= 2;
        if (c[5] && e[20:16] != 0) m[`IDX_IRQ_STATUS] |= 4;
        lvl <= nv;
        repeat (10) @(posedge clk);
    endtask

    task automatic chk_outputs;
        logic [7:0] c, md0, md1, md2;
        repeat (2) @(posedge clk);
        c   = 8'(m[`IDX_PORT_IRQ_CTL]);
        md0 = 8'(m[`IDX_P0_INMODE]);
        md1 = 8'(m[`IDX_P1_INMODE]);
        md2 = 8'(m[`IDX_P2_INMODE]);
        chk("pull_en", {~md2[4:0], ~md1 & `P1_MODE_MASK, ~md0}, {pe2, pe1, pe0});
        chk("pull_dir", md2[7:5], dir);
        chk("cpu_irq0", |(m[`IDX_P0_FLAGS] & {c[4], c[4], c[4], c[4], c[3], c[3], c[3], c[3]}),
            cpu[0]);
        chk("cpu_irq1", |(m[`IDX_P1_FLAGS] & m[`IDX_P1_IRQ_EN]), cpu[1]);
        chk("cpu_irq2", c[5] && m[`IDX_P2_FLAGS] != 0, cpu[2]);
        chk("irq", (m[`IDX_IRQ_STATUS] & m[`IDX_IRQ_MASK]) != 0, irq);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, lvl} = '0;
        drive = 1'b1;
        srst = 1'b1;
        seed = 32'h20da;
        for (int i = 0; i < 10; i++) m[mapped[i]] = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (m[k]) rd(8'(k));
        chk_outputs();
        rd(8'h00);
        wr(8'h90, 8'hff);
        repeat (8) begin
            wr(`IDX_P0_INMODE, 8'($random(seed)));
            wr(`IDX_P1_INMODE, 8'($random(seed)));
            wr(`IDX_P2_INMODE, 8'($random(seed)));
            wr(`IDX_PORT_IRQ_CTL, 8'($random(seed)));
            wr(`IDX_P1_IRQ_EN, 8'($random(seed)));
            wr(`IDX_IRQ_MASK, 8'($random(seed)));
            pins_to(21'($random(seed)));
            chk_outputs();
            foreach (m[k]) rd(8'(k));
            wr(`IDX_P0_FLAGS, 8'($random(seed)));
            wr(`IDX_P1_FLAGS, 8'($random(seed)));
            wr(`IDX_P2_FLAGS, 8'($random(seed)));
            chk_outputs();
        end
        complete_run();
    end

    initial begin
        #400000;
        num_errors++;
        complete_run();
    end
endmodule
